/* rtl/dma_chan_regs.vh */
// register offsets, field positions and reset values of the dma channel block
`ifndef DMA_CHAN_REGS_VH
`define DMA_CHAN_REGS_VH
`define CFG_OFF 12'h100
`define STAT_OFF 12'h104
`define SRC_OFF 12'h108
`define DST_OFF 12'h10C
`define CNT_OFF 12'h110
`define SRC_RLD_OFF 12'h114
`define DST_RLD_OFF 12'h118
`define CNT_RLD_OFF 12'h11C
`define ST_TO 6
`define ST_BERR 4
`define ST_RLD 3
`define ST_CTZ 2
`define ST_IPEND 1
`define ST_ACT 0
`define CFG_EN 0
`define CFG_RLDEN 1
`define CFG_CTZIE 31
`define CFG_SRCINC 18
`define CFG_DSTINC 22
`define CFG_PERIPH 30
`define CNT_RLDEN 31
`define CFG_WMASK 32'hC0770003
`define RST_ZERO 32'h00000000
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* rtl/dma_channel.v */
// dma channel: apb registers, address stepping, byte counting, status flags
// Overview of operation
// - time-out sets flag bit 6, write-1 clears
// - bus error sets bit 4, disables channel
// - reload sets bit 3, write-1 clears
// - count zero sets bit 2 if enabled
// - pending bit 1 high when any flag set
// - pending falls when flags cleared; unwritable
// - bit 0 shows channel active, read-only
// - active bit clears when channel stops
// - clearing active also clears channel enable
// - peripheral mode forces both read and write addresses to zero
// - source address steps by read beat size if enabled
// - destination address steps by width if enabled
// - counter decrements by bytes moved per read beat
// - counter reaching zero raises count-zero
// - count-zero with reload copies reload values
// - reload enable self-clears after reload
// - width field sizes transfer, read beats shorter near end
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_regs.vh"
module dma_channel (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  output reg [31:0] haddr,
  output reg hwrite,
  output reg [1:0] htrans,
  output reg [2:0] hsize,
  output reg [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hready,
  input wire hresp,
  input wire timeout_pin,
  output wire channel_busy
);
  // -------------------------------------------------------------
  // state encodings
  // -------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_RD = 5'b00010;
  localparam [4:0] S_WR = 5'b00100;
  localparam [4:0] S_DATA = 5'b01000;
  localparam [4:0] S_ADDR = 5'b10000;

  reg [31:0] channel_configuration;
  reg [31:0] source_address;
  reg [31:0] destination_address;
  reg [23:0] transfer_byte_count;
  reg [30:0] source_reload_value;
  reg [30:0] destination_reload_value;
  reg [23:0] count_reload_value;
  reg timeout_flag;
  reg bus_err_flag;
  reg reload_done_flag;
  reg count_zero_flag;
  reg channel_active;
  reg [4:0] state;
  reg [4:0] ret_state;
  reg [2:0] step;
  reg to_s1;
  reg to_s2;
  reg to_prev;
  wire apb_wr;
  wire apb_rd;
  wire stat_wr;
  wire to_evt;
  wire ipend;
  wire [2:0] src_b;
  wire [2:0] dst_b;
  wire [2:0] src_step;
  wire [2:0] dst_step;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire rd_done;
  wire wr_done;
  wire beat_err;
  wire [23:0] cnt_next;
  wire ctz_evt;
  wire rld_now;
  wire stop_evt;
  wire drained;
  wire periph;
  wire [31:0] cur_rdata;

  // -------------------------------------------------------------
  // apb slave: zero-wait, unmapped reads zero and flag pslverr
  // -------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite && ce;
  assign apb_rd = psel && !penable && !pwrite;
  assign stat_wr = apb_wr && (paddr == `STAT_OFF);
  assign pslverr = psel && penable && (paddr[11:5] != 7'h08);

  // width decode: 11 reserved maps to byte
  function [2:0] width_bytes;
    input [1:0] w;
    begin
      case (w)
        2'b01: width_bytes = 3'd2;
        2'b10: width_bytes = 3'd4;
        default: width_bytes = 3'd1;
      endcase
    end
  endfunction

  // shorter beat once fewer bytes remain; never an odd three-byte beat
  function [2:0] clip;
    input [2:0] b;
    input [23:0] left;
    begin
      if (left >= {21'd0, b})
        clip = b;
      else if (left >= 24'd2)
        clip = 3'd2;
      else
        clip = 3'd1;
    end
  endfunction

  assign src_b = width_bytes(channel_configuration[17:16]);
  assign dst_b = width_bytes(channel_configuration[21:20]);
  assign src_step = clip(src_b, transfer_byte_count);
  assign dst_step = dst_b;
  assign periph = channel_configuration[`CFG_PERIPH];

  // -------------------------------------------------------------
  // time-out input synchroniser and rising edge
  // -------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      to_s1 <= 1'b0;
      to_s2 <= 1'b0;
      to_prev <= 1'b0;
    end
    else if (ce)
    begin
      to_s1 <= timeout_pin;
      to_s2 <= to_s1;
      to_prev <= to_s2;
    end
  end
  assign to_evt = to_s2 && !to_prev && channel_active;

  // -------------------------------------------------------------
  // ahb beat completion terms
  // -------------------------------------------------------------
  assign rd_done = (state == S_DATA) && (ret_state == S_RD) && hready;
  assign wr_done = (state == S_DATA) && (ret_state == S_WR) && hready;
  assign beat_err = (state == S_DATA) && hready && hresp;
  assign cnt_next = transfer_byte_count - {21'd0, step};
  assign ctz_evt = rd_done && !hresp && (cnt_next == 24'd0);
  assign rld_now = ctz_evt && channel_configuration[`CFG_RLDEN];
  // count spent and fifo empty: last word is out, so stopping loses nothing
  assign drained = (state == S_IDLE) && (transfer_byte_count == 24'd0)
                   && !fifo_out_valid;
  assign stop_evt = beat_err || to_evt
                    || drained || !channel_configuration[`CFG_EN];

  // data path fifo; the write side drains it, read side stalls when full
  dma_fifo #(
    .WIDTH(32),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(rd_done && !hresp),
    .in_ready(fifo_in_ready),
    .in_data(hrdata),
    .out_valid(fifo_out_valid),
    .out_ready(wr_done && !hresp),
    .out_data(fifo_out_data)
  );

  // -------------------------------------------------------------
  // ahb master sequencer: read beat into fifo, write beat out of it
  // -------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      ret_state <= S_IDLE;
      step <= 3'd0;
      haddr <= `RST_ZERO;
      hwrite <= 1'b0;
      htrans <= 2'b00;
      hsize <= 3'd0;
      hwdata <= `RST_ZERO;
    end
    else if (ce)
    begin
      case (state)
        S_IDLE:
        begin
          htrans <= 2'b00;
          if (channel_active && channel_configuration[`CFG_EN])
          begin
            if (fifo_out_valid)
              state <= S_WR;
            else if (fifo_in_ready && transfer_byte_count != 24'd0)
              state <= S_RD;
          end
        end
        S_RD:
        begin
          haddr <= periph ? `RST_ZERO : source_address;
          hwrite <= 1'b0;
          htrans <= 2'b10;
          hsize <= {1'b0, src_step[2], src_step[1]};
          step <= src_step;
          ret_state <= S_RD;
          state <= S_ADDR;
        end
        S_WR:
        begin
          haddr <= periph ? `RST_ZERO : destination_address;
          hwrite <= 1'b1;
          htrans <= 2'b10;
          hsize <= {1'b0, dst_step[2], dst_step[1]};
          step <= dst_step;
          ret_state <= S_WR;
          state <= S_ADDR;
        end
        // address phase; write data goes out with the following data phase
        S_ADDR:
        begin
          if (hready)
          begin
            htrans <= 2'b00;
            if (ret_state == S_WR)
              hwdata <= fifo_out_data;
            state <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (hready)
            state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // configuration, address, count and reload registers
  // -------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      channel_configuration <= `RST_ZERO;
      source_address <= `RST_ZERO;
      destination_address <= `RST_ZERO;
      transfer_byte_count <= 24'd0;
      source_reload_value <= 31'd0;
      destination_reload_value <= 31'd0;
      count_reload_value <= 24'd0;
      channel_active <= 1'b0;
    end
    else if (ce)
    begin
      if (apb_wr)
      begin
        case (paddr)
          `CFG_OFF: channel_configuration <= pwdata & `CFG_WMASK;
          `SRC_OFF: source_address <= pwdata;
          `DST_OFF: destination_address <= pwdata;
          `CNT_OFF: transfer_byte_count <= pwdata[23:0];
          `SRC_RLD_OFF: source_reload_value <= pwdata[30:0];
          `DST_RLD_OFF: destination_reload_value <= pwdata[30:0];
          `CNT_RLD_OFF:
          begin
            count_reload_value <= pwdata[23:0];
            channel_configuration[`CFG_RLDEN] <= pwdata[`CNT_RLDEN];
          end
          default: ;
        endcase
      end
      // channel goes active when software enables it
      if (apb_wr && paddr == `CFG_OFF && pwdata[`CFG_EN])
        channel_active <= 1'b1;
      // read beat: step source and count
      if (rd_done && !hresp)
      begin
        if (channel_configuration[`CFG_SRCINC] && !periph)
          source_address <= source_address + {29'd0, step};
        transfer_byte_count <= cnt_next;
      end
      if (wr_done && !hresp && channel_configuration[`CFG_DSTINC] && !periph)
        destination_address <= destination_address + {29'd0, step};
      if (rld_now)
      begin
        source_address <= {1'b0, source_reload_value};
        destination_address <= {1'b0, destination_reload_value};
        transfer_byte_count <= count_reload_value;
        channel_configuration[`CFG_RLDEN] <= 1'b0;
      end
      // stop clears active and enable together
      if (channel_active && stop_evt)
      begin
        channel_active <= 1'b0;
        channel_configuration[`CFG_EN] <= 1'b0;
      end
    end
  end
  assign channel_busy = channel_active;

  // -------------------------------------------------------------
  // sticky status flags: set wins over write-one clear
  // -------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      timeout_flag <= 1'b0;
      bus_err_flag <= 1'b0;
      reload_done_flag <= 1'b0;
      count_zero_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (to_evt)
        timeout_flag <= 1'b1;
      else if (stat_wr && pwdata[`ST_TO])
        timeout_flag <= 1'b0;
      if (beat_err)
        bus_err_flag <= 1'b1;
      else if (stat_wr && pwdata[`ST_BERR])
        bus_err_flag <= 1'b0;
      if (rld_now)
        reload_done_flag <= 1'b1;
      else if (stat_wr && pwdata[`ST_RLD])
        reload_done_flag <= 1'b0;
      if (ctz_evt && channel_configuration[`CFG_CTZIE])
        count_zero_flag <= 1'b1;
      else if (stat_wr && pwdata[`ST_CTZ])
        count_zero_flag <= 1'b0;
    end
  end

  // pending is pure function of flags so it falls with them
  assign ipend = timeout_flag | bus_err_flag | reload_done_flag | count_zero_flag;

  // -------------------------------------------------------------
  // read mux, registered in setup so data sits still in access
  // -------------------------------------------------------------
  assign cur_rdata =
    (paddr == `CFG_OFF) ? channel_configuration :
    (paddr == `STAT_OFF) ? {25'd0, timeout_flag, 1'b0, bus_err_flag,
                            reload_done_flag, count_zero_flag, ipend,
                            channel_active} :
    (paddr == `SRC_OFF) ? source_address :
    (paddr == `DST_OFF) ? destination_address :
    (paddr == `CNT_OFF) ? {8'd0, transfer_byte_count} :
    (paddr == `SRC_RLD_OFF) ? {1'b0, source_reload_value} :
    (paddr == `DST_RLD_OFF) ? {1'b0, destination_reload_value} :
    (paddr == `CNT_RLD_OFF) ? {channel_configuration[`CFG_RLDEN], 7'd0,
                               count_reload_value} :
    `RST_ZERO;

  always @(posedge clk)
  begin
    if (!rst_n)
      prdata <= `RST_ZERO;
    else if (ce && apb_rd)
      prdata <= cur_rdata;
  end
endmodule // dma_channel
`default_nettype wire

/* rtl/dma_fifo.v */
// sixteen-word data fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dma_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] level;
  wire push;
  wire pop;

  // honest full and empty from the level count
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  // storage array, no reset needed on data
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and level
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        level <= level + 1'b1;
      else if (pop && !push)
        level <= level - 1'b1;
    end
  end
endmodule // dma_fifo
`default_nettype wire

/* tb/ahb_mem_model.sv */
// behavioural ahb memory answering the dma channel's bus cycles
`timescale 1ns/1ns
`default_nettype none
module ahb_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hwdata,
  input wire logic [3:0] wait_cycles,
  input wire logic err_on,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp
);
  logic [31:0] mem [0:63];
  logic [31:0] last;
  logic [5:0] a;
  logic [3:0] cnt;
  logic busy;
  logic wr;
  // ----------------------------------------
  // data phase ends once the wait count runs out
  // ----------------------------------------
  assign hready = !busy || cnt == 4'h0;
  assign hresp = busy && cnt == 4'h0 && err_on;
  // outside a data phase the bus toggles, so a stale word never matches
  assign hrdata = (busy && cnt == 4'h0) ? mem[a] : ~last;
  // a nonseq address phase is taken only while ready; reset loads known words
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      last <= 32'h0;
      a <= 6'h0;
      cnt <= 4'h0;
      wr <= 1'b0;
      for (int i = 0; i < 64; i++)
        mem[i] <= 32'hA5000000 + i;
    end
    else
    begin
      last <= hrdata;
      // write lands at the end of an error-free data phase
      if (busy && cnt == 4'h0 && wr && !err_on)
        mem[a] <= hwdata;
      if (htrans == 2'b10 && hready)
      begin
        busy <= 1'b1;
        a <= haddr[7:2];
        cnt <= wait_cycles;
        wr <= hwrite;
      end
      else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else
        busy <= 1'b0;
    end
  end
endmodule // ahb_mem_model
`default_nettype wire

/* tb/dma_channel_properties.sv */
// port assertions of the dma channel
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_regs.vh"
module dma_channel_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hresp,
  input wire logic channel_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // status reads and bus faults
  // ----------------------------------------
  sequence stat_read;
    psel && penable && !pwrite && paddr == `STAT_OFF;
  endsequence
  sequence bus_fault;
    channel_busy && hready && hresp;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_unmapped_err: assert property (psel && penable && (paddr < 12'h100 || paddr > 12'h11F) |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_stat_reserved: assert property (stat_read |-> prdata[31:7] == 25'h0 && !prdata[5])
    else $error("reserved status bit set");
  chk_pend_summary: assert property (stat_read |-> prdata[1] == |{prdata[6], prdata[4:2]})
    else $error("pending bit disagrees with flags");
  chk_active_shown: assert property (stat_read |-> prdata[0] == $past(channel_busy))
    else $error("active bit disagrees with busy");
  chk_fault_stops: assert property (bus_fault |-> ##[1:4] !channel_busy)
    else $error("channel still busy after bus error");
  chk_idle_quiet: assert property (!channel_busy [*3] |-> htrans == 2'b00)
    else $error("bus cycle while channel idle");
  chk_reset_clear: assert property ($rose(rst_n) |-> !channel_busy && htrans == 2'b00)
    else $error("outputs not cleared by reset");
  chk_freeze_ce: assert property (!ce |=> $stable(channel_busy) && $stable(htrans) && $stable(haddr))
    else $error("state moved with ce low");
  chk_addr_once: assert property (htrans == 2'b10 |=> htrans == 2'b00)
    else $error("address phase longer than one cycle");
  chk_size_legal: assert property (htrans == 2'b10 |-> hsize <= 3'd2)
    else $error("transfer size wider than a word");
endmodule // dma_channel_properties
bind dma_channel dma_channel_properties i_dma_channel_properties (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pready(pready),
  .prdata(prdata),
  .pslverr(pslverr),
  .haddr(haddr),
  .htrans(htrans),
  .hsize(hsize),
  .hready(hready),
  .hresp(hresp),
  .channel_busy(channel_busy)
);
`default_nettype wire

/* tb/dma_channel_tb.sv */
// self-checking bench for the dma channel
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_regs.vh"
module dma_channel_tb;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, hwrite, hready, hresp;
  logic timeout_pin, channel_busy, err_on, periph, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, last_size;
  logic [3:0] wait_cycles;
  int mismatches = 0;
  int total_checks = 0;
  dma_channel i_dma_channel (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .haddr(haddr),
    .hwrite(hwrite),
    .htrans(htrans),
    .hsize(hsize),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hready(hready),
    .hresp(hresp),
    .timeout_pin(timeout_pin),
    .channel_busy(channel_busy)
  );
  ahb_mem_model i_ahb_mem_model (
    .clk(clk),
    .rst_n(rst_n),
    .haddr(haddr),
    .hwrite(hwrite),
    .htrans(htrans),
    .hwdata(hwdata),
    .wait_cycles(wait_cycles),
    .err_on(err_on),
    .hrdata(hrdata),
    .hready(hready),
    .hresp(hresp)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_of_test;
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_of_test;
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  // bounded wait; a channel that never stops ends the run
  task wait_idle;
    int n;
    n = 0;
    while (channel_busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (channel_busy !== 1'b0)
    begin
      mismatches++;
      end_of_test;
    end
  endtask
  // sampled on the falling edge, clear of the design's own updates
  always @(negedge clk)
  begin
    if (periph && htrans == 2'b10)
      chk("haddr", 32'h0, haddr);
    if (htrans == 2'b10 && !hwrite)
      last_size = hsize;
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    timeout_pin = 1'b0;
    err_on = 1'b0;
    periph = 1'b0;
    wait_cycles = 4'h2;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(12'h104 + 12'(4 * i), 32'h0);
    wr(`SRC_OFF, 32'hFFFFFFFF);
    rd(`SRC_OFF, 32'hFFFFFFFF);
    wr(`CNT_OFF, 32'hFFFFFFFF);
    rd(`CNT_OFF, 32'h00FFFFFF);
    rd(12'h200, 32'h0);
    chk("pslverr", 32'h1, {31'h0, last_err});
    // four-byte reads, last one clipped to the two bytes left
    wr(`SRC_OFF, 32'h10);
    wr(`DST_OFF, 32'h200);
    wr(`CNT_OFF, 32'h6);
    wr(`CFG_OFF, 32'h80260001);
    wait_idle;
    rd(`SRC_OFF, 32'h16);
    rd(`DST_OFF, 32'h200);
    rd(`CNT_OFF, 32'h0);
    rd(`STAT_OFF, 32'h6);
    rd(`CFG_OFF, 32'h80260000);
    chk("hsize", 32'h1, {29'h0, last_size});
    chk("dst_word", 32'hA5000005, i_ahb_mem_model.mem[0]);
    wr(`STAT_OFF, 32'h0);
    rd(`STAT_OFF, 32'h6);
    wr(`STAT_OFF, 32'h2);
    rd(`STAT_OFF, 32'h6);
    wr(`STAT_OFF, 32'h4);
    rd(`STAT_OFF, 32'h0);
    // one armed reload, then a second count-zero stops the channel
    wait_cycles <= 4'h0;
    wr(`SRC_RLD_OFF, 32'h40);
    wr(`DST_RLD_OFF, 32'h80);
    wr(`CNT_RLD_OFF, 32'h80000004);
    wr(`SRC_OFF, 32'h20);
    wr(`CNT_OFF, 32'h2);
    wr(`CFG_OFF, 32'h80040003);
    wait_idle;
    rd(`SRC_OFF, 32'h44);
    rd(`DST_OFF, 32'h80);
    rd(`CNT_RLD_OFF, 32'h4);
    rd(`STAT_OFF, 32'hE);
    wr(`STAT_OFF, 32'hC);
    // error answer from the far side
    err_on <= 1'b1;
    wr(`CNT_OFF, 32'h8);
    wr(`CFG_OFF, 32'h1);
    wait_idle;
    err_on <= 1'b0;
    rd(`STAT_OFF, 32'h12);
    rd(`CFG_OFF, 32'h0);
    wr(`STAT_OFF, 32'h10);
    rd(`STAT_OFF, 32'h0);
    // slow far side, time-out raised mid-run
    wait_cycles <= 4'hF;
    wr(`CNT_OFF, 32'h100);
    wr(`CFG_OFF, 32'h1);
    timeout_pin <= 1'b1;
    wait_idle;
    timeout_pin <= 1'b0;
    rd(`STAT_OFF, 32'h42);
    wr(`STAT_OFF, 32'h40);
    rd(`STAT_OFF, 32'h0);
    // peripheral mode, count-zero flag not enabled
    wait_cycles <= 4'h0;
    repeat (20) @(posedge clk);
    periph <= 1'b1;
    wr(`CNT_OFF, 32'h3);
    wr(`CFG_OFF, 32'h40040001);
    wait_idle;
    periph <= 1'b0;
    rd(`STAT_OFF, 32'h0);
    end_of_test;
  end
endmodule // dma_channel_tb
`default_nettype wire
